// ===== hw/miu_pkg.sv
// Purpose: shared constants for the interrupt unit
// Assumes: APB slave, 32-bit data, one aligned word per register
// Notes:   offsets are byte addresses
package miu_pkg;
   localparam logic [11:0] OFF_FLAGS = 12'h000;
   localparam logic [11:0] OFF_MASK  = 12'h004;
   localparam logic [11:0] OFF_CTRL  = 12'h008;
   localparam logic [11:0] OFF_HTHR  = 12'h00C;
   localparam logic [11:0] OFF_LTHR  = 12'h010;
   localparam logic [11:0] OFF_CAPT  = 12'h014;
   localparam logic [11:0] OFF_STAT  = 12'h018;
   localparam logic [15:0] VEC_LOW   = 16'h0001;
   localparam logic [15:0] VEC_HIGH  = 16'h000A;
   localparam int FL_TICK = 0;
   localparam int FL_EP0  = 1;
   localparam int FL_SUSP = 2;
   localparam int FL_BRST = 3;
   localparam int FL_RSM  = 4;
   localparam int FL_PORT = 5;
   localparam int FL_HPAT = 6;
   localparam int FL_LPAT = 7;
   // bits routed to the low entry; the rest go to the high entry
   localparam logic [7:0] LOW_GROUP  = 8'hE1;
   localparam logic [7:0] FLAGS_RST  = 8'h00;
   localparam logic [7:0] MASK_RST   = 8'h00;
   // ctrl: 0 pattern enable, 1 run, 2 full clock, 3 kbd serial mode
   localparam int CT_PAT  = 0;
   localparam int CT_RUN  = 1;
   localparam int CT_FCLK = 2;
   localparam int CT_KBD  = 3;
   localparam logic [3:0] CTRL_RST   = 4'h6;
   localparam logic [7:0] CNT_MAX    = 8'hFF;
endpackage

// ===== hw/miu_pattern.sv
// Purpose: pattern length counter with high/low length events
// Assumes: serial input already synchronous
// Notes:   counter saturates at max; reports on reaching max and again when that pattern ends
`timescale 1ns/1ps
`default_nettype none
module miu_pattern
   import miu_pkg::*;
(
   // clock and reset
   input  wire logic       sys_clk_in,
   input  wire logic       nrst_in,
   // control
   input  wire logic       en_in,
   input  wire logic [7:0] hthr_in,
   input  wire logic [7:0] lthr_in,
   input  wire logic       ser_in,
   // results
   output logic            hi_evt_out,
   output logic            lo_evt_out,
   output logic [7:0]      capt_out
);
   typedef struct packed {
      logic       lvl;
      logic [7:0] cnt;
      logic       over;
      logic       hi;
      logic       lo;
      logic [7:0] capt;
   } miu_pat_s;
   miu_pat_s st_ff, nxt_st;

   always_comb begin
      nxt_st = st_ff;
      nxt_st.hi = 1'b0;
      nxt_st.lo = 1'b0;
      nxt_st.lvl = ser_in;
      if (!en_in) begin
         nxt_st.cnt = 8'h00;
         nxt_st.over = 1'b0;
      end else if (ser_in != st_ff.lvl) begin
         nxt_st.capt = st_ff.cnt;
         // fall ends a high pattern, rise ends a low one
         if (st_ff.lvl)
            nxt_st.hi = st_ff.over || (st_ff.cnt > hthr_in);
         else
            nxt_st.lo = st_ff.over || (st_ff.cnt > lthr_in);
         nxt_st.cnt = 8'h00;
         nxt_st.over = 1'b0;
      end else if (st_ff.cnt != CNT_MAX) begin
         nxt_st.cnt = st_ff.cnt + 8'h01;
         // level held until the count reaches max
         if (st_ff.cnt + 8'h01 == CNT_MAX) begin
            nxt_st.hi = st_ff.lvl;
            nxt_st.lo = !st_ff.lvl;
         end
      end else begin
         nxt_st.over = 1'b1;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (!nrst_in)
         st_ff <= '0;
      else
         st_ff <= nxt_st;
   end

   assign hi_evt_out = st_ff.hi;
   assign lo_evt_out = st_ff.lo;
   assign capt_out   = st_ff.capt;

   a_pat_off: assert property (
      @(posedge sys_clk_in) disable iff (!nrst_in)
      !en_in |=> !hi_evt_out && !lo_evt_out)
      else $error("pattern event while disabled");
endmodule
`default_nettype wire

// ===== hw/miu_vector.sv
// Purpose: picks the entry address for pending enabled sources
// Assumes: inputs already gated by mask and global enable
// Notes:   low entry group wins when both are pending
`timescale 1ns/1ps
`default_nettype none
module miu_vector
   import miu_pkg::*;
(
   // request
   input  wire logic [7:0]  live_in,
   // result
   output logic             take_out,
   output logic [15:0]      vec_out
);
   always_comb begin
      take_out = |live_in;
      // low group serviced first
      if (|(live_in & LOW_GROUP))
         vec_out = VEC_LOW;
      else
         vec_out = VEC_HIGH;
   end
endmodule
`default_nettype wire

// ===== hw/miu_top.sv
// Purpose: interrupt unit with flags, mask, global enable and wake control
// Assumes: core pulses instruction strobes; sources are one-cycle pulses
// Notes:   registers over APB; flags cleared by writing one
`timescale 1ns/1ps
`default_nettype none
module miu_top
   import miu_pkg::*;
(
   // clock and reset
   input  wire logic        sys_clk_in,
   input  wire logic        nrst_in,
   // apb slave
   input  wire logic        psel_in,
   input  wire logic        penable_in,
   input  wire logic        pwrite_in,
   input  wire logic [11:0] paddr_in,
   input  wire logic [31:0] pwdata_in,
   input  wire logic [3:0]  pstrb_in,
   output logic [31:0]      prdata_out,
   output logic             pready_out,
   output logic             pslverr_out,
   // core instruction strobes
   input  wire logic        global_irq_on_instr_in,
   input  wire logic        global_irq_off_instr_in,
   input  wire logic        return_and_irq_on_instr_in,
   input  wire logic        core_ack_in,
   // event sources
   input  wire logic        tick_overflow_in,
   input  wire logic        ep0_setup_in,
   input  wire logic        ep0_supported_in,
   input  wire logic        usb_suspend_in,
   input  wire logic        usb_bus_reset_in,
   input  wire logic        usb_resume_in,
   input  wire logic [1:0]  port_pins_in,
   input  wire logic        pattern_in,
   input  wire logic        watchdog_reset_in,
   // core side results
   output logic             irq_take_out,
   output logic [15:0]      irq_vector_out,
   output logic             global_irq_en_out,
   output logic             core_run_out,
   output logic             full_clock_out
);
   typedef struct packed {
      logic [7:0]  flags;
      logic [7:0]  mask;
      logic [3:0]  ctrl;
      logic [7:0]  hthr;
      logic [7:0]  lthr;
      logic        gie;
      logic [1:0]  pins;
      logic        take;
      logic [15:0] vec;
      logic [31:0] rdata;
   } miu_top_s;
   miu_top_s st_ff, nxt_st;

   logic        hi_evt;
   logic        lo_evt;
   logic [7:0]  capt;
   logic [7:0]  live;
   logic        sel_take;
   logic [15:0] sel_vec;
   logic [7:0]  evt;
   logic        wr_acc;
   logic        rd_acc;
   logic        port_chg;

   function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
      return a == o;
   endfunction

   miu_pattern u_pat (
      .sys_clk_in (sys_clk_in),
      .nrst_in    (nrst_in),
      .en_in      (st_ff.ctrl[CT_PAT]),
      .hthr_in    (st_ff.hthr),
      .lthr_in    (st_ff.lthr),
      .ser_in     (pattern_in),
      .hi_evt_out (hi_evt),
      .lo_evt_out (lo_evt),
      .capt_out   (capt)
   );

   // gated by flag, mask and global enable
   assign live = st_ff.gie ? (st_ff.flags & st_ff.mask) : 8'h00;

   miu_vector u_vec (
      .live_in  (live),
      .take_out (sel_take),
      .vec_out  (sel_vec)
   );

   // only one pin watched unless keyboard mode
   assign port_chg = st_ff.ctrl[CT_KBD] ? |(port_pins_in ^ st_ff.pins)
                                        : (port_pins_in[0] ^ st_ff.pins[0]);

   always_comb begin
      evt = 8'h00;
      evt[FL_TICK] = tick_overflow_in;
      evt[FL_EP0]  = ep0_setup_in && !ep0_supported_in;
      evt[FL_SUSP] = usb_suspend_in;
      evt[FL_BRST] = usb_bus_reset_in;
      // resume event only while on slow clock
      evt[FL_RSM]  = usb_resume_in && !st_ff.ctrl[CT_FCLK];
      evt[FL_PORT] = port_chg;
      evt[FL_HPAT] = hi_evt;
      evt[FL_LPAT] = lo_evt;
   end

   assign wr_acc = psel_in && penable_in && pwrite_in;
   assign rd_acc = psel_in && !penable_in && !pwrite_in;

   always_comb begin
      nxt_st = st_ff;
      nxt_st.pins = port_pins_in;
      if (wr_acc && pstrb_in[0]) begin
         if (hit(paddr_in, OFF_FLAGS))
            nxt_st.flags = st_ff.flags & ~pwdata_in[7:0];
         if (hit(paddr_in, OFF_MASK))
            nxt_st.mask = pwdata_in[7:0];
         if (hit(paddr_in, OFF_CTRL))
            nxt_st.ctrl = pwdata_in[3:0];
         if (hit(paddr_in, OFF_HTHR))
            nxt_st.hthr = pwdata_in[7:0];
         if (hit(paddr_in, OFF_LTHR))
            nxt_st.lthr = pwdata_in[7:0];
      end
      // set beats clear; mask not consulted
      nxt_st.flags = nxt_st.flags | evt;
      // wake events set the run bit again
      if (usb_resume_in || watchdog_reset_in || port_chg)
         nxt_st.ctrl[CT_RUN] = 1'b1;
      // take held until the core acknowledges
      if (st_ff.take) begin
         if (core_ack_in)
            nxt_st.take = 1'b0;
      end else if (sel_take && st_ff.ctrl[CT_RUN]) begin
         nxt_st.take = 1'b1;
         nxt_st.vec = sel_vec;
         nxt_st.gie = 1'b0;
      end
      if (global_irq_off_instr_in)
         nxt_st.gie = 1'b0;
      else if (global_irq_on_instr_in || return_and_irq_on_instr_in)
         nxt_st.gie = 1'b1;
      if (rd_acc) begin
         unique case (paddr_in)
            OFF_FLAGS: nxt_st.rdata = {24'h0000_00, st_ff.flags};
            OFF_MASK:  nxt_st.rdata = {24'h0000_00, st_ff.mask};
            OFF_CTRL:  nxt_st.rdata = {28'h000_0000, st_ff.ctrl};
            OFF_HTHR:  nxt_st.rdata = {24'h0000_00, st_ff.hthr};
            OFF_LTHR:  nxt_st.rdata = {24'h0000_00, st_ff.lthr};
            OFF_CAPT:  nxt_st.rdata = {24'h0000_00, capt};
            OFF_STAT:  nxt_st.rdata = {15'h0000, st_ff.gie, st_ff.vec};
            default:   nxt_st.rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (!nrst_in) begin
         st_ff <= '0;
         st_ff.ctrl <= CTRL_RST;
         st_ff.flags <= FLAGS_RST;
         st_ff.mask <= MASK_RST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // unmapped addresses answer with an error
   always_comb begin
      pready_out  = 1'b1;
      pslverr_out = psel_in && penable_in && !(hit(paddr_in, OFF_FLAGS) ||
         hit(paddr_in, OFF_MASK) || hit(paddr_in, OFF_CTRL) ||
         hit(paddr_in, OFF_HTHR) || hit(paddr_in, OFF_LTHR) ||
         hit(paddr_in, OFF_CAPT) || hit(paddr_in, OFF_STAT));
   end

   assign prdata_out        = st_ff.rdata;
   assign irq_take_out      = st_ff.take;
   assign irq_vector_out    = st_ff.vec;
   assign global_irq_en_out = st_ff.gie;
   assign core_run_out      = st_ff.ctrl[CT_RUN];
   assign full_clock_out    = st_ff.ctrl[CT_FCLK];

   sequence s_tick;
      tick_overflow_in;
   endsequence

   // idle, running, enabled, and an unmasked flag pending
   sequence s_ready_to_take;
      !st_ff.take && st_ff.ctrl[CT_RUN] && st_ff.gie
         && ((st_ff.flags & st_ff.mask) != 8'h00);
   endsequence

   // redirect still waiting for the core
   sequence s_take_waiting;
      st_ff.take && !core_ack_in;
   endsequence

   // the core accepts the redirect on this edge
   sequence s_take_acked;
      st_ff.take && core_ack_in;
   endsequence

   // mask write that actually lands
   sequence s_mask_write;
      wr_acc && pstrb_in[0] && hit(paddr_in, OFF_MASK);
   endsequence

   a_tick_flag: assert property (
      @(posedge sys_clk_in) disable iff (!nrst_in)
      s_tick |=> st_ff.flags[FL_TICK])
      else $error("tick flag not set");
   a_ep0_flag: assert property (
      @(posedge sys_clk_in) disable iff (!nrst_in)
      (ep0_setup_in && !ep0_supported_in) |=> st_ff.flags[FL_EP0])
      else $error("endpoint-0 flag not set");
   a_ep0_supp: assert property (
      @(posedge sys_clk_in) disable iff (!nrst_in)
      (ep0_setup_in && ep0_supported_in && !st_ff.flags[FL_EP0])
         |=> !st_ff.flags[FL_EP0])
      else $error("supported request flagged");
   a_susp_flag: assert property (
      @(posedge sys_clk_in) disable iff (!nrst_in)
      usb_suspend_in |=> st_ff.flags[FL_SUSP])
      else $error("suspend flag not set");
   a_brst_flag: assert property (
      @(posedge sys_clk_in) disable iff (!nrst_in)
      usb_bus_reset_in |=> st_ff.flags[FL_BRST])
      else $error("bus reset flag not set");
   a_rsm_flag: assert property (
      @(posedge sys_clk_in) disable iff (!nrst_in)
      (usb_resume_in && !st_ff.ctrl[CT_FCLK]) |=> st_ff.flags[FL_RSM])
      else $error("resume flag not set");
   a_rsm_fast: assert property (
      @(posedge sys_clk_in) disable iff (!nrst_in)
      (st_ff.ctrl[CT_FCLK] && !st_ff.flags[FL_RSM])
         |=> !st_ff.flags[FL_RSM])
      else $error("resume flagged on full clock");
   a_port_flag: assert property (
      @(posedge sys_clk_in) disable iff (!nrst_in)
      port_chg |=> st_ff.flags[FL_PORT])
      else $error("port change flag not set");
   a_kbd_pin: assert property (
      @(posedge sys_clk_in) disable iff (!nrst_in)
      (st_ff.ctrl[CT_KBD] && (port_pins_in[1] != st_ff.pins[1]))
         |=> st_ff.flags[FL_PORT])
      else $error("second pin ignored in keyboard mode");
   a_hpat_flag: assert property (
      @(posedge sys_clk_in) disable iff (!nrst_in)
      hi_evt |=> st_ff.flags[FL_HPAT])
      else $error("high pattern flag not set");
   a_lpat_flag: assert property (
      @(posedge sys_clk_in) disable iff (!nrst_in)
      lo_evt |=> st_ff.flags[FL_LPAT])
      else $error("low pattern flag not set");
   a_set_wins: assert property (
      @(posedge sys_clk_in) disable iff (!nrst_in)
      (evt != 8'h00)
         |=> ((st_ff.flags & $past(evt)) == $past(evt)))
      else $error("event lost against a clear");
   a_mask_block: assert property (
      @(posedge sys_clk_in) disable iff (!nrst_in)
      (!st_ff.take && st_ff.mask == 8'h00) |=> !st_ff.take)
      else $error("take with all masked");
   a_bit_mask: assert property (
      @(posedge sys_clk_in) disable iff (!nrst_in)
      (!st_ff.take && ((st_ff.flags & st_ff.mask) == 8'h00))
         |=> !st_ff.take)
      else $error("take without an unmasked flag");
   a_gie_block: assert property (
      @(posedge sys_clk_in) disable iff (!nrst_in)
      (!st_ff.take && !st_ff.gie) |=> !st_ff.take)
      else $error("take with enable off");
   a_take_rise: assert property (
      @(posedge sys_clk_in) disable iff (!nrst_in)
      s_ready_to_take |=> st_ff.take)
      else $error("pending interrupt not taken");
   a_take_clear: assert property (
      @(posedge sys_clk_in) disable iff (!nrst_in)
      $rose(st_ff.take) |-> !st_ff.gie || $past(global_irq_on_instr_in)
         || $past(return_and_irq_on_instr_in))
      else $error("enable left on after take");
   a_take_hold: assert property (
      @(posedge sys_clk_in) disable iff (!nrst_in)
      s_take_waiting |=> st_ff.take && $stable(st_ff.vec))
      else $error("redirect dropped before acceptance");
   a_take_drop: assert property (
      @(posedge sys_clk_in) disable iff (!nrst_in)
      s_take_acked |=> !st_ff.take)
      else $error("redirect held after acceptance");
   a_take_vec: assert property (
      @(posedge sys_clk_in) disable iff (!nrst_in)
      st_ff.take
         |-> (st_ff.vec == VEC_LOW) || (st_ff.vec == VEC_HIGH))
      else $error("redirect to an unknown entry");
   a_low_first: assert property (
      @(posedge sys_clk_in) disable iff (!nrst_in)
      ($rose(st_ff.take) && $past(|(live & LOW_GROUP)))
         |-> st_ff.vec == VEC_LOW)
      else $error("low group not first");
   a_high_vec: assert property (
      @(posedge sys_clk_in) disable iff (!nrst_in)
      (!st_ff.take && st_ff.ctrl[CT_RUN] && ((live & LOW_GROUP) == 8'h00)
         && (live != 8'h00)) |=> st_ff.vec == VEC_HIGH)
      else $error("high group not sent to high entry");
   a_off_instr: assert property (
      @(posedge sys_clk_in) disable iff (!nrst_in)
      global_irq_off_instr_in |=> !st_ff.gie)
      else $error("off instruction ignored");
   a_on_instr: assert property (
      @(posedge sys_clk_in) disable iff (!nrst_in)
      ((global_irq_on_instr_in || return_and_irq_on_instr_in)
         && !global_irq_off_instr_in) |=> st_ff.gie)
      else $error("on instruction ignored");
   a_mask_write: assert property (
      @(posedge sys_clk_in) disable iff (!nrst_in)
      s_mask_write |=> st_ff.mask == $past(pwdata_in[7:0]))
      else $error("mask write lost");
   a_no_sleep: assert property (
      @(posedge sys_clk_in) disable iff (!nrst_in)
      (!st_ff.take && !st_ff.ctrl[CT_RUN]) |=> !st_ff.take)
      else $error("take while asleep");
   a_wake_run: assert property (
      @(posedge sys_clk_in) disable iff (!nrst_in)
      watchdog_reset_in |=> core_run_out)
      else $error("no wake");
   a_wake_port: assert property (
      @(posedge sys_clk_in) disable iff (!nrst_in)
      (port_chg || usb_resume_in) |=> core_run_out)
      else $error("no wake on port change or resume");
endmodule
`default_nettype wire

// ===== bench/miu_core_model.sv
// Purpose: core stand-in that accepts redirects from the interrupt unit
// Assumes: take holds until the ack edge
// Notes:   dly_in sets how long the core lingers before jumping
`timescale 1ns/1ps
`default_nettype none
module miu_core_model (
   // clock and reset
   input  wire logic        sys_clk_in,
   input  wire logic        nrst_in,
   // redirect request
   input  wire logic        take_in,
   input  wire logic [15:0] vec_in,
   input  wire logic [3:0]  dly_in,
   // acceptance
   output logic             ack_out,
   output logic [15:0]      pc_out,
   output logic [7:0]       taken_out
);
   logic [3:0] wait_ff;

   // one ack per request; take is still high on the ack edge itself
   always_ff @(posedge sys_clk_in) begin
      if (!nrst_in) begin
         wait_ff   <= 4'h0;
         ack_out   <= 1'b0;
         pc_out    <= 16'h0000;
         taken_out <= 8'h00;
      end else begin
         ack_out <= 1'b0;
         if (take_in && !ack_out) begin
            if (wait_ff == dly_in) begin
               ack_out   <= 1'b1;
               pc_out    <= vec_in;
               taken_out <= taken_out + 8'h01;
               wait_ff   <= 4'h0;
            end else begin
               wait_ff <= wait_ff + 4'h1;
            end
         end
      end
   end
endmodule
`default_nettype wire

// ===== bench/tb_top.sv
// Purpose: self-checking bench for the interrupt unit
// Assumes: zero-wait APB slave, core model acks every redirect
// Notes:   pattern counter counts every clock, no prescaler
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import miu_pkg::*;
   logic        clk, nrst, psel, pen, pwr, prdy, perr, er, ack;
   logic        sup, pat, take, gie, run, fck;
   logic [11:0] adr;
   logic [31:0] wd, rd, q;
   logic [8:0]  pul;
   logic [1:0]  pins;
   logic [15:0] vec, pc;
   logic [7:0]  ntk;
   logic [3:0]  dly;
   int          mismatches, n_compared;

   miu_top miu_top_inst (
      .sys_clk_in(clk), .nrst_in(nrst), .psel_in(psel),
      .penable_in(pen), .pwrite_in(pwr), .paddr_in(adr),
      .pwdata_in(wd), .pstrb_in(4'hF), .prdata_out(rd),
      .pready_out(prdy), .pslverr_out(perr),
      .global_irq_on_instr_in(pul[6]),
      .global_irq_off_instr_in(pul[7]),
      .return_and_irq_on_instr_in(pul[8]), .core_ack_in(ack),
      .tick_overflow_in(pul[0]), .ep0_setup_in(pul[1]),
      .ep0_supported_in(sup), .usb_suspend_in(pul[2]),
      .usb_bus_reset_in(pul[3]), .usb_resume_in(pul[4]),
      .port_pins_in(pins), .pattern_in(pat),
      .watchdog_reset_in(pul[5]), .irq_take_out(take),
      .irq_vector_out(vec), .global_irq_en_out(gie),
      .core_run_out(run), .full_clock_out(fck)
   );

   miu_core_model miu_core_model_inst (
      .sys_clk_in(clk), .nrst_in(nrst), .take_in(take), .vec_in(vec),
      .dly_in(dly), .ack_out(ack), .pc_out(pc), .taken_out(ntk)
   );

   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      n_compared++;
      if (s !== e) begin
         mismatches++;
         $display("FAIL %0t seen %h expected %h", $time, s, e);
      end
   endtask

   task automatic chb(input logic s, input logic e);
      chk({31'h0, s}, {31'h0, e});
   endtask

   // request held until pready is seen high at a rising edge
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwr  <= w;
      adr  <= a;
      wd   <= d;
      @(posedge clk);
      pen <= 1'b1;
      @(posedge clk);
      while (prdy !== 1'b1) @(posedge clk);
      q = rd;
      er = perr;
      psel <= 1'b0;
      pen  <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rc(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0000_0000);
      chk(q, e);
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic pulse(input int i);
      @(posedge clk);
      pul[i] <= 1'b1;
      @(posedge clk);
      pul[i] <= 1'b0;
   endtask

   task automatic waitk(input logic [7:0] n);
      int k;
      k = 0;
      while (ntk !== n && k < 40) begin
         @(posedge clk);
         k++;
      end
      chk({24'h0, ntk}, {24'h0, n});
   endtask

   task automatic done(input string s);
      $display("test %s finished", s);
   endtask

   task automatic conclude;
      $display("compared %0d mismatched %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // whole run is well under a thousand cycles
   initial begin
      cyc(20000);
      mismatches++;
      conclude();
   end

   initial begin
      nrst = 1'b0;
      psel = 1'b0;
      pen = 1'b0;
      pwr = 1'b0;
      adr = 12'h000;
      wd = 32'h0000_0000;
      pul = 9'h000;
      sup = 1'b0;
      pins = 2'b00;
      pat = 1'b0;
      dly = 4'h0;
      cyc(16);
      nrst <= 1'b1;
      rc(OFF_FLAGS, 32'h0000_0000);
      rc(OFF_MASK, 32'h0000_0000);
      rc(OFF_CTRL, 32'h0000_0006);
      rc(OFF_STAT, 32'h0000_0000);
      chb(fck, 1'b1);
      wr(12'h01C, 32'h0000_00FF);
      chb(er, 1'b1);
      rc(OFF_MASK, 32'h0000_0000);
      done("reset");
      // the first six sources latch while masked; supported ep0 and full-clock resume do not
      for (int i = 0; i < 4; i++) begin
         pulse(i);
         rc(OFF_FLAGS, 32'h0000_0001 << i);
         wr(OFF_FLAGS, 32'h0000_00FF);
      end
      sup <= 1'b1;
      pulse(1);
      rc(OFF_FLAGS, 32'h0000_0000);
      sup <= 1'b0;
      pulse(4);
      rc(OFF_FLAGS, 32'h0000_0000);
      wr(OFF_CTRL, 32'h0000_0002);
      pulse(4);
      chb(fck, 1'b0);
      rc(OFF_FLAGS, 32'h0000_0010);
      wr(OFF_FLAGS, 32'h0000_00FF);
      pins <= 2'b10;
      cyc(2);
      rc(OFF_FLAGS, 32'h0000_0000);
      pins <= 2'b11;
      cyc(2);
      rc(OFF_FLAGS, 32'h0000_0020);
      wr(OFF_FLAGS, 32'h0000_00FF);
      wr(OFF_CTRL, 32'h0000_000E);
      pins <= 2'b01;
      cyc(2);
      rc(OFF_FLAGS, 32'h0000_0020);
      wr(OFF_FLAGS, 32'h0000_00FF);
      done("sources");
      // both groups pending: low entry first, high after return
      pulse(0);
      pulse(2);
      wr(OFF_MASK, 32'h0000_00FF);
      cyc(3);
      chb(take, 1'b0);
      pulse(6);
      waitk(8'h01);
      chk({16'h0, pc}, {16'h0, VEC_LOW});
      chb(gie, 1'b0);
      rc(OFF_STAT, {16'h0000, VEC_LOW});
      wr(OFF_FLAGS, 32'h0000_0001);
      dly <= 4'h5;
      pulse(8);
      waitk(8'h02);
      chk({16'h0, pc}, {16'h0, VEC_HIGH});
      rc(OFF_STAT, {16'h0000, VEC_HIGH});
      wr(OFF_FLAGS, 32'h0000_0004);
      pulse(8);
      cyc(3);
      chb(gie, 1'b1);
      chb(take, 1'b0);
      wr(OFF_MASK, 32'h0000_00FE);
      pulse(0);
      cyc(3);
      chb(take, 1'b0);
      pulse(7);
      cyc(1);
      chb(gie, 1'b0);
      wr(OFF_FLAGS, 32'h0000_00FF);
      done("interrupts");
      wr(OFF_HTHR, 32'h0000_0005);
      rc(OFF_HTHR, 32'h0000_0005);
      wr(OFF_LTHR, 32'h0000_00FE);
      wr(OFF_CTRL, 32'h0000_0007);
      pat <= 1'b1;
      cyc(10);
      pat <= 1'b0;
      cyc(4);
      rc(OFF_FLAGS, 32'h0000_0040);
      wr(OFF_FLAGS, 32'h0000_00FF);
      cyc(300);
      rc(OFF_FLAGS, 32'h0000_0080);
      wr(OFF_FLAGS, 32'h0000_00FF);
      pat <= 1'b1;
      cyc(4);
      rc(OFF_FLAGS, 32'h0000_0080);
      rc(OFF_CAPT, 32'h0000_00FF);
      // run cleared, watchdog wakes the core
      wr(OFF_CTRL, 32'h0000_0004);
      cyc(2);
      chb(run, 1'b0);
      pulse(5);
      cyc(2);
      chb(run, 1'b1);
      done("pattern and sleep");
      conclude();
   end
endmodule
`default_nettype wire
